// ==== logic/plcr_pkg.sv ====
package plcr_pkg;

   // Register offsets on the plain register port.
   localparam logic [7:0] PLCR_OFF_PHOTO_CONTROL    = 8'h10;
   localparam logic [7:0] PLCR_OFF_LED_LEVEL_FIRST  = 8'h11;
   localparam logic [7:0] PLCR_OFF_LED_LEVEL_SECOND = 8'h12;

   localparam int unsigned PLCR_ADDR_W = 8;
   localparam int unsigned PLCR_DATA_W = 8;

   // Reset values.
   localparam logic [7:0] PLCR_RST_PHOTO_CONTROL = 8'h00;
   localparam logic [7:0] PLCR_RST_LED_LEVEL     = 8'h00;

   // Writable bits of the photo control register; bit 7 is reserved.
   localparam logic [7:0] PLCR_PHOTO_CONTROL_WMASK = 8'h7F;
   // Every bit of a level register is writable.
   localparam logic [7:0] PLCR_LED_LEVEL_WMASK     = 8'hFF;

   // Field positions in the photo control register.
   localparam int unsigned PLCR_SECOND_TC_LSB = 5;
   localparam int unsigned PLCR_FIRST_TC_LSB  = 3;
   localparam int unsigned PLCR_PREF_BIT      = 2;
   localparam int unsigned PLCR_GAIN_LSB      = 0;
   localparam int unsigned PLCR_TC_W          = 2;
   localparam int unsigned PLCR_GAIN_W        = 2;

   // Temperature coefficient codes, in mV per degree.
   typedef enum logic [1:0] {
      PLCR_TC_0P347 = 2'b00,
      PLCR_TC_0P416 = 2'b01,
      PLCR_TC_0P693 = 2'b10,
      PLCR_TC_1P040 = 2'b11
   } plcr_tc_type;

   // Photo gain stage codes.
   typedef enum logic [1:0] {
      PLCR_GAIN_5  = 2'b00,
      PLCR_GAIN_11 = 2'b01,
      PLCR_GAIN_20 = 2'b10,
      PLCR_GAIN_35 = 2'b11
   } plcr_gain_type;

   // Unmapped offsets read as this value.
   localparam logic [7:0] PLCR_RD_UNMAPPED = 8'h00;

endpackage

// ==== logic/plcr_reg8.sv ====
`timescale 1ns/10ps
module plcr_reg8 #(
   parameter logic [7:0] RST_VAL = 8'h00,
   parameter logic [7:0] WMASK   = 8'hFF
) (
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       we_i,
   input  wire logic [7:0] wdata_i,
   output logic      [7:0] q_o
);

   logic [7:0] val_d;
   logic [7:0] val_q;

   // Masked bits hold their reset value, so reserved bits read back as zero.
   always_comb begin
      val_d = val_q;
      if (we_i) begin
         val_d = (wdata_i & WMASK) | (RST_VAL & ~WMASK);
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         val_q <= RST_VAL;
      end else begin
         val_q <= val_d;
      end
   end

   assign q_o = val_q;

endmodule

// ==== logic/plcr_top.sv ====
// What this block does
// - The photo control register sits at offset 0x10, resets to zero, and its bit 7 is read-only zero.
// - Bits 6 to 5 of photo control select the second LED driver temperature coefficient, 0.347 to 1.040 mV per degree.
// - Bits 4 to 3 of photo control select the first LED driver temperature coefficient with the same four codes.
// - Bit 2 of photo control picks the photo reference: zero grounds the gain amplifier, one uses the internal 50 mV reference.
// - Bits 1 to 0 of photo control pick a photo gain of 5, 11, 20 or 35.
// - The first DAC level sits at offset 0x11 and the second at 0x12, both resetting to zero.
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/10ps
module plcr_top (
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic [7:0] addr_i,
   input  wire logic [7:0] wdata_i,
   input  wire logic       wr_i,
   input  wire logic       rd_i,
   output logic      [7:0] rdata_o,
   output logic      [1:0] second_driver_tc_select_o,
   output logic      [1:0] first_driver_tc_select_o,
   output logic            photo_reference_select_o,
   output logic      [1:0] photo_gain_select_o,
   output logic      [7:0] first_driver_level_o,
   output logic      [7:0] second_driver_level_o
);

   logic       we_ctrl;
   logic       we_first;
   logic       we_second;
   logic [7:0] ctrl_q;
   logic [7:0] first_q;
   logic [7:0] second_q;
   logic [7:0] rdata_d;
   logic [7:0] rdata_q;

   // Address decode for writes.
   always_comb begin
      we_ctrl   = 1'b0;
      we_first  = 1'b0;
      we_second = 1'b0;
      if (wr_i && addr_i == plcr_pkg::PLCR_OFF_PHOTO_CONTROL) begin
         we_ctrl = 1'b1;
      end else if (wr_i && addr_i == plcr_pkg::PLCR_OFF_LED_LEVEL_FIRST) begin
         we_first = 1'b1;
      end else if (wr_i && addr_i == plcr_pkg::PLCR_OFF_LED_LEVEL_SECOND) begin
         we_second = 1'b1;
      end
   end

   // Bit 7 is masked off so it stays zero whatever is written.
   plcr_reg8 #(
      .RST_VAL (plcr_pkg::PLCR_RST_PHOTO_CONTROL),
      .WMASK   (plcr_pkg::PLCR_PHOTO_CONTROL_WMASK)
   ) u_ctrl (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .we_i    (we_ctrl),
      .wdata_i (wdata_i),
      .q_o     (ctrl_q)
   );

   plcr_reg8 #(
      .RST_VAL (plcr_pkg::PLCR_RST_LED_LEVEL),
      .WMASK   (plcr_pkg::PLCR_LED_LEVEL_WMASK)
   ) u_first (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .we_i    (we_first),
      .wdata_i (wdata_i),
      .q_o     (first_q)
   );

   plcr_reg8 #(
      .RST_VAL (plcr_pkg::PLCR_RST_LED_LEVEL),
      .WMASK   (plcr_pkg::PLCR_LED_LEVEL_WMASK)
   ) u_second (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .we_i    (we_second),
      .wdata_i (wdata_i),
      .q_o     (second_q)
   );

   // Read data stand only in the cycle after the strobe, zero otherwise.
   always_comb begin
      rdata_d = plcr_pkg::PLCR_RD_UNMAPPED;
      if (rd_i && addr_i == plcr_pkg::PLCR_OFF_PHOTO_CONTROL) begin
         rdata_d = ctrl_q;
      end else if (rd_i && addr_i == plcr_pkg::PLCR_OFF_LED_LEVEL_FIRST) begin
         rdata_d = first_q;
      end else if (rd_i && addr_i == plcr_pkg::PLCR_OFF_LED_LEVEL_SECOND) begin
         rdata_d = second_q;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_q <= plcr_pkg::PLCR_RD_UNMAPPED;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   assign rdata_o = rdata_q;

   // Analog settings come straight from the register flip-flops.
   assign second_driver_tc_select_o =
      ctrl_q[plcr_pkg::PLCR_SECOND_TC_LSB +: plcr_pkg::PLCR_TC_W];
   assign first_driver_tc_select_o =
      ctrl_q[plcr_pkg::PLCR_FIRST_TC_LSB +: plcr_pkg::PLCR_TC_W];
   assign photo_reference_select_o = ctrl_q[plcr_pkg::PLCR_PREF_BIT];
   assign photo_gain_select_o =
      ctrl_q[plcr_pkg::PLCR_GAIN_LSB +: plcr_pkg::PLCR_GAIN_W];
   // The level is the raw code; the trim by bin is done by host software.
   assign first_driver_level_o  = first_q;
   assign second_driver_level_o = second_q;

endmodule

// ==== tb/plcr_monitor.sv ====
`timescale 1ns/10ps
module plcr_monitor (
   input wire logic       clk_i,
   input wire logic       rst_i,
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic       wr_i,
   input wire logic       rd_i,
   input wire logic [7:0] rdata_o,
   input wire logic [1:0] second_driver_tc_select_o,
   input wire logic [1:0] first_driver_tc_select_o,
   input wire logic       photo_reference_select_o,
   input wire logic [1:0] photo_gain_select_o,
   input wire logic [7:0] first_driver_level_o,
   input wire logic [7:0] second_driver_level_o
);
   logic [6:0] ctl;
   assign ctl = {second_driver_tc_select_o, first_driver_tc_select_o,
                 photo_reference_select_o, photo_gain_select_o};
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_ctl_write: assert property (wr_i && addr_i == 8'h10 |=>
      ctl == $past(wdata_i[6:0])) else $error("control write lost");
   a_first_write: assert property (wr_i && addr_i == 8'h11 |=>
      first_driver_level_o == $past(wdata_i)) else $error("first write lost");
   a_second_write: assert property (wr_i && addr_i == 8'h12 |=>
      second_driver_level_o == $past(wdata_i)) else $error("second write lost");
   a_first_hold: assert property (!(wr_i && addr_i == 8'h11) |=>
      $stable(first_driver_level_o)) else $error("first level moved");
   a_second_hold: assert property (!(wr_i && addr_i == 8'h12) |=>
      $stable(second_driver_level_o)) else $error("second level moved");
   a_ctl_hold: assert property (!(wr_i && addr_i == 8'h10) |=>
      $stable(ctl)) else $error("control moved");
   a_ctl_read: assert property (rd_i && addr_i == 8'h10 |=>
      rdata_o == {1'b0, $past(ctl)}) else $error("control read wrong");
   a_first_read: assert property (rd_i && addr_i == 8'h11 |=>
      rdata_o == $past(first_driver_level_o)) else $error("first read wrong");
   a_second_read: assert property (rd_i && addr_i == 8'h12 |=>
      rdata_o == $past(second_driver_level_o)) else $error("second read bad");
   a_unmapped_read: assert property (rd_i &&
      (addr_i < 8'h10 || addr_i > 8'h12) |=> rdata_o == 8'h00)
      else $error("unmapped read not zero");
endmodule
bind plcr_top plcr_monitor i_mon (.clk_i, .rst_i, .addr_i, .wdata_i, .wr_i,
   .rd_i, .rdata_o, .second_driver_tc_select_o, .first_driver_tc_select_o,
   .photo_reference_select_o, .photo_gain_select_o, .first_driver_level_o,
   .second_driver_level_o);

// ==== tb/plcr_top_tb.sv ====
`timescale 1ns/10ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin miscompares++; \
   $display("mismatch t=%0t got %h exp %h", $time, (a), (e)); end end
module plcr_top_tb;
   logic       clk_i = 1'b0;
   logic       rst_i = 1'b1;
   logic [7:0] addr_i = 8'h00;
   logic [7:0] wdata_i = 8'h00;
   logic       wr_i = 1'b0;
   logic       rd_i = 1'b0;
   logic [7:0] rdata_o, lvl1, lvl2;
   logic [1:0] tc2, tc1, gain;
   logic       pref;
   int         checks = 0;
   int         miscompares = 0;
   int         cyc = 0;
   always #2 clk_i = ~clk_i;
   plcr_top i_dut (.clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
      .second_driver_tc_select_o(tc2), .first_driver_tc_select_o(tc1),
      .photo_reference_select_o(pref), .photo_gain_select_o(gain),
      .first_driver_level_o(lvl1), .second_driver_level_o(lvl2));
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 `CHK(rdata_o, e)
   endtask
   task results;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 3000) begin
         miscompares++;
         results();
      end
   end
   initial begin
      logic [1:0] k;
      logic [7:0] trim [4] = '{8'h11, 8'h06, 8'hFA, 8'hEF};
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      rd_chk(8'h10, 8'h00);
      rd_chk(8'h11, 8'h00);
      rd_chk(8'h12, 8'h00);
      wr_reg(8'h10, 8'hFF);
      rd_chk(8'h10, 8'h7F);
      for (int i = 0; i < 4; i++) begin
         k = 2'(i);
         wr_reg(8'h10, {1'b1, k, ~k, k[0], k});
         #1 `CHK({tc2, tc1, pref, gain}, {k, ~k, k[0], k})
         rd_chk(8'h10, {1'b0, k, ~k, k[0], k});
      end
      for (int i = 0; i < 4; i++) begin
         wr_reg(8'h11, 8'h14 + trim[i]);
         rd_chk(8'h11, 8'h14 + trim[i]);
      end
      wr_reg(8'h11, 8'hFF);
      wr_reg(8'h12, 8'hA5);
      #1 `CHK({lvl1, lvl2}, 16'hFFA5)
      wr_reg(8'h13, 8'h55);
      rd_chk(8'h13, 8'h00);
      rd_chk(8'h12, 8'hA5);
      @(posedge clk_i);
      #1 `CHK(rdata_o, 8'h00)
      @(posedge clk_i);
      rst_i <= 1'b1;
      @(posedge clk_i);
      rst_i <= 1'b0;
      rd_chk(8'h11, 8'h00);
      rd_chk(8'h12, 8'h00);
      rd_chk(8'h10, 8'h00);
      #1 `CHK({tc2, tc1, pref, gain, lvl1, lvl2}, 23'h0)
      results();
   end
endmodule
